// File: ldc_consts.vh
// constants for the lcd drive control register bank
// assumes inclusion by its bare name from each design file
`ifndef LDC_CONSTS_VH
`define LDC_CONSTS_VH

// ----------------------------------------------------------------
// register word indices (byte address is four times the index)
// ----------------------------------------------------------------
`define LDC_IDX_CTRL 2'h0
`define LDC_IDX_SEL_LOW 2'h1
`define LDC_IDX_SEL_MID 2'h2
`define LDC_IDX_SEL_HIGH 2'h3
`define LDC_ADDR_W 4

// ----------------------------------------------------------------
// field positions of the control register
// ----------------------------------------------------------------
`define LDC_FRAME_BIT 7
`define LDC_BIAS_HI_BIT 6
`define LDC_BIAS_LO_BIT 5
`define LDC_MASTER_BIT 4

// ----------------------------------------------------------------
// implemented-bit masks and reset value
// ----------------------------------------------------------------
`define LDC_MASK_CTRL 8'hF0
`define LDC_MASK_SEL_LOW 8'hCF
`define LDC_MASK_SEL_MID 8'hDB
`define LDC_MASK_SEL_HIGH 8'h1F
`define LDC_RESET_BYTE 8'h00
`define LDC_PIN_EXISTS 24'h1FDBCF

// ----------------------------------------------------------------
// bias resistor codes
// ----------------------------------------------------------------
`define LDC_BIAS_LARGEST 2'h0
`define LDC_BIAS_LARGE 2'h1
`define LDC_BIAS_SMALL 2'h2
`define LDC_BIAS_SMALLEST 2'h3

// ----------------------------------------------------------------
// pin level codes
// ----------------------------------------------------------------
`define LDC_LVL_VSS 2'h0
`define LDC_LVL_THIRD 2'h1
`define LDC_LVL_TWO_THIRDS 2'h2
`define LDC_LVL_VDD 2'h3

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define LDC_PIN_COUNT 21
`define LDC_BUS_W 32
`define LDC_BYTE_W 8
`define LDC_ZERO_PAD 24'h000000

`endif

// File: ldc_reg_byte.v
// one byte of the register bank with a mask of implemented bits
// assumes a write strobe already qualified by the bus slave
`include "ldc_consts.vh"

module ldc_reg_byte #(
    parameter [7:0] IMPL_MASK = 8'hFF
) (
    input wire clk_in,
    input wire nrst_in,
    input wire wr_en_in,
    input wire [7:0] wr_data_in,
    output wire [7:0] value_out
);

    reg [7:0] value_q;
    wire [7:0] value_d;

    // masked bits never store, so reserved and unimplemented bits stay zero
    assign value_d = wr_en_in ? (wr_data_in & IMPL_MASK) : value_q;

    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            value_q <= `LDC_RESET_BYTE;
        end else begin
            value_q <= value_d;
        end
    end

    assign value_out = value_q;

endmodule // ldc_reg_byte

// File: ldc_pin_drive.v
// level selection for one shared common/segment pin
// assumes port data and pin-share select come from logic on clk_in
`include "ldc_consts.vh"

module ldc_pin_drive (
    input wire clk_in,
    input wire nrst_in,
    input wire pin_exists_in,
    input wire master_on_in,
    input wire frame_in,
    input wire is_segment_in,
    input wire port_data_in,
    input wire share_sel_in,
    output wire [1:0] level_out,
    output wire drive_out
);

    reg [1:0] level_q;
    reg [1:0] level_d;
    reg drive_q;
    wire drive_d;

    // port direction is not consulted: the lcd path drives on its own
    assign drive_d = pin_exists_in & master_on_in & share_sel_in;

    always @* begin
        level_d = `LDC_LVL_VSS;
        if (!master_on_in) begin
            level_d = `LDC_LVL_VSS;
        end else begin
            case ({frame_in, is_segment_in})
                2'h0: level_d = port_data_in ? `LDC_LVL_VDD : `LDC_LVL_THIRD;
                2'h1: level_d = port_data_in ? `LDC_LVL_VSS : `LDC_LVL_TWO_THIRDS;
                2'h2: level_d = port_data_in ? `LDC_LVL_VSS : `LDC_LVL_TWO_THIRDS;
                2'h3: level_d = port_data_in ? `LDC_LVL_VDD : `LDC_LVL_THIRD;
                default: level_d = `LDC_LVL_VSS;
            endcase
        end
    end

    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            level_q <= `LDC_LVL_VSS;
            drive_q <= 1'b0;
        end else begin
            level_q <= level_d;
            drive_q <= drive_d;
        end
    end

    assign level_out = level_q;
    assign drive_out = drive_q;

endmodule // ldc_pin_drive

// File: ldc_top.v
// lcd common/segment drive control registers and per-pin level selection
// assumes an avalon-mm master on clk_in and port data from same-clock logic
//
// How it works
// - control bit 7 picks frame polarity for all common and segment pins.
// - control bits 6..5 pick one of four bias ladder resistances, 00 largest.
// - control bit 4 is master on; when clear every pin sits at ground.
// - unimplemented control bits 3..0 and high select bits 7..6 read zero.
// - a role bit of 0 makes its pin common, 1 makes it segment.
// - low select bits 7,6,3..0 steer pins 7,6,3..0.
// - low select bits 5 and 4 are reserved and ignore writes.
// - mid bits 5 and 2, and high bit 5, are reserved and ignore writes.
// - high select bits 4..0 steer pins 20..16.
// - each pin level comes from frame bit and its own port data bit.
// - lcd driving needs no port direction setup by software.
// - frame 0 common vdd or third, segment vss or two thirds; frame 1 swaps.
`include "ldc_consts.vh"

module ldc_top (
    input wire clk_in,
    input wire nrst_in,
    input wire [`LDC_ADDR_W-1:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [`LDC_BUS_W-1:0] avs_writedata_in,
    input wire [3:0] avs_byteenable_in,
    output wire [`LDC_BUS_W-1:0] avs_readdata_out,
    output wire avs_waitrequest_out,
    input wire [`LDC_PIN_COUNT-1:0] port_data_in,
    input wire [`LDC_PIN_COUNT-1:0] pin_share_sel_in,
    output wire [2*`LDC_PIN_COUNT-1:0] pin_level_out,
    output wire [`LDC_PIN_COUNT-1:0] pin_drive_out,
    output wire [`LDC_PIN_COUNT-1:0] pin_is_segment_out,
    output wire frame_out,
    output wire lcd_drive_master_on_out,
    output wire [3:0] bias_resistor_onehot_out
);

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------

    // word address hits a register; high address bits must be zero
    function mapped;
        input [`LDC_ADDR_W-1:0] addr;
        begin
            mapped = (addr[`LDC_ADDR_W-1:2] == 2'h0);
        end
    endfunction

    function [3:0] bias_onehot;
        input [1:0] code;
        begin
            case (code)
                `LDC_BIAS_LARGEST: bias_onehot = 4'h1;
                `LDC_BIAS_LARGE: bias_onehot = 4'h2;
                `LDC_BIAS_SMALL: bias_onehot = 4'h4;
                `LDC_BIAS_SMALLEST: bias_onehot = 4'h8;
                default: bias_onehot = 4'h1;
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // avalon slave handshake
    // ----------------------------------------------------------------
    // every access takes two cycles: the first raises waitrequest,
    // the second completes; this keeps readdata registered
    reg ack_q;
    wire ack_d;
    wire req;
    wire hit;
    wire commit_wr;
    reg [`LDC_BUS_W-1:0] rdata_q;
    reg [`LDC_BUS_W-1:0] rdata_d;

    assign req = avs_read_in | avs_write_in;
    assign hit = mapped(avs_address_in);
    assign ack_d = req & ~ack_q;
    assign avs_waitrequest_out = req & ~ack_q;
    // write lands only at the edge where waitrequest is seen low
    assign commit_wr = avs_write_in & ack_q & hit & avs_byteenable_in[0];

    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= ack_d;
        end
    end

    // ----------------------------------------------------------------
    // register bytes
    // ----------------------------------------------------------------
    wire [7:0] ctrl_val;
    wire [7:0] sel_low_val;
    wire [7:0] sel_mid_val;
    wire [7:0] sel_high_val;
    wire wr_ctrl;
    wire wr_low;
    wire wr_mid;
    wire wr_high;

    assign wr_ctrl = commit_wr & (avs_address_in[1:0] == `LDC_IDX_CTRL);
    assign wr_low = commit_wr & (avs_address_in[1:0] == `LDC_IDX_SEL_LOW);
    assign wr_mid = commit_wr & (avs_address_in[1:0] == `LDC_IDX_SEL_MID);
    assign wr_high = commit_wr & (avs_address_in[1:0] == `LDC_IDX_SEL_HIGH);

    // masks keep reserved and unimplemented bits at zero
    ldc_reg_byte #(
        .IMPL_MASK(`LDC_MASK_CTRL)
    ) u_ctrl (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .wr_en_in(wr_ctrl),
        .wr_data_in(avs_writedata_in[`LDC_BYTE_W-1:0]),
        .value_out(ctrl_val)
    );

    // bits 5..4 reserved, never altered
    ldc_reg_byte #(
        .IMPL_MASK(`LDC_MASK_SEL_LOW)
    ) u_sel_low (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .wr_en_in(wr_low),
        .wr_data_in(avs_writedata_in[`LDC_BYTE_W-1:0]),
        .value_out(sel_low_val)
    );

    // bits 5 and 2 reserved, never altered
    ldc_reg_byte #(
        .IMPL_MASK(`LDC_MASK_SEL_MID)
    ) u_sel_mid (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .wr_en_in(wr_mid),
        .wr_data_in(avs_writedata_in[`LDC_BYTE_W-1:0]),
        .value_out(sel_mid_val)
    );

    // bit 5 reserved, bits 7..6 absent
    ldc_reg_byte #(
        .IMPL_MASK(`LDC_MASK_SEL_HIGH)
    ) u_sel_high (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .wr_en_in(wr_high),
        .wr_data_in(avs_writedata_in[`LDC_BYTE_W-1:0]),
        .value_out(sel_high_val)
    );

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    // unmapped addresses read as zero; writes to them are dropped
    always @* begin
        rdata_d = {`LDC_ZERO_PAD, `LDC_RESET_BYTE};
        if (hit) begin
            case (avs_address_in[1:0])
                `LDC_IDX_CTRL: rdata_d = {`LDC_ZERO_PAD, ctrl_val};
                `LDC_IDX_SEL_LOW: rdata_d = {`LDC_ZERO_PAD, sel_low_val};
                `LDC_IDX_SEL_MID: rdata_d = {`LDC_ZERO_PAD, sel_mid_val};
                `LDC_IDX_SEL_HIGH: rdata_d = {`LDC_ZERO_PAD, sel_high_val};
                default: rdata_d = {`LDC_ZERO_PAD, `LDC_RESET_BYTE};
            endcase
        end
    end

    // captured in the wait cycle, stands through the completing edge
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdata_q <= {`LDC_ZERO_PAD, `LDC_RESET_BYTE};
        end else if (avs_read_in & ~ack_q) begin
            rdata_q <= rdata_d;
        end
    end

    assign avs_readdata_out = rdata_q;

    // ----------------------------------------------------------------
    // control fields
    // ----------------------------------------------------------------
    wire frame_sel;
    wire master_on;
    wire [1:0] bias_code;
    reg [3:0] bias_q;
    reg frame_q;
    reg master_q;

    assign frame_sel = ctrl_val[`LDC_FRAME_BIT];
    assign master_on = ctrl_val[`LDC_MASTER_BIT];
    assign bias_code = {ctrl_val[`LDC_BIAS_HI_BIT], ctrl_val[`LDC_BIAS_LO_BIT]};

    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            bias_q <= 4'h1;
            frame_q <= 1'b0;
            master_q <= 1'b0;
        end else begin
            bias_q <= bias_onehot(bias_code);
            frame_q <= frame_sel;
            master_q <= master_on;
        end
    end

    assign bias_resistor_onehot_out = bias_q;
    assign frame_out = frame_q;
    assign lcd_drive_master_on_out = master_q;

    // ----------------------------------------------------------------
    // pin role mapping and level generation
    // ----------------------------------------------------------------
    // pin n lines up with bit n of the three select bytes in a row
    wire [23:0] role_all;
    wire [23:0] pin_exists;
    reg [`LDC_PIN_COUNT-1:0] seg_q;

    assign role_all = {sel_high_val, sel_mid_val, sel_low_val};
    assign pin_exists = `LDC_PIN_EXISTS;

    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            seg_q <= {`LDC_PIN_COUNT{1'b0}};
        end else begin
            seg_q <= role_all[`LDC_PIN_COUNT-1:0];
        end
    end

    assign pin_is_segment_out = seg_q;

    genvar gi;
    generate
        for (gi = 0; gi < `LDC_PIN_COUNT; gi = gi + 1) begin : g_pin
            // level from frame and port data; ground while off
            // drive enable ignores port direction
            ldc_pin_drive u_drive (
                .clk_in(clk_in),
                .nrst_in(nrst_in),
                .pin_exists_in(pin_exists[gi]),
                .master_on_in(master_on),
                .frame_in(frame_sel),
                .is_segment_in(role_all[gi]),
                .port_data_in(port_data_in[gi]),
                .share_sel_in(pin_share_sel_in[gi]),
                .level_out(pin_level_out[2*gi+1:2*gi]),
                .drive_out(pin_drive_out[gi])
            );
        end
    endgenerate

endmodule // ldc_top

// File: ldc_top_properties.sv
// assertions on the ports of the lcd drive register bank
// assumes a bind onto ldc_top, one clock, async active-low reset
`include "ldc_consts.vh"

module ldc_top_properties (
    input wire clk_in,
    input wire nrst_in,
    input wire [`LDC_ADDR_W-1:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [`LDC_BUS_W-1:0] avs_writedata_in,
    input wire [3:0] avs_byteenable_in,
    input wire [`LDC_BUS_W-1:0] avs_readdata_out,
    input wire avs_waitrequest_out,
    input wire [`LDC_PIN_COUNT-1:0] port_data_in,
    input wire [`LDC_PIN_COUNT-1:0] pin_share_sel_in,
    input wire [2*`LDC_PIN_COUNT-1:0] pin_level_out,
    input wire [`LDC_PIN_COUNT-1:0] pin_drive_out,
    input wire [`LDC_PIN_COUNT-1:0] pin_is_segment_out,
    input wire frame_out,
    input wire lcd_drive_master_on_out,
    input wire [3:0] bias_resistor_onehot_out
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam [15:0] LV_TBL = 16'hD22D;
    wire done = (avs_read_in || avs_write_in) && !avs_waitrequest_out;
    wire [3:0] oh = bias_resistor_onehot_out;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!nrst_in);

    // level code indexed by frame, role, data
    function automatic [1:0] lv(input f, input s, input d);
        lv = LV_TBL[{f, s, d, 1'b0} +: 2];
    endfunction

    property p_wait_ans;
        (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out;
    endproperty
    a_wait_ans: assert property (p_wait_ans) else $error("no answer in second cycle");
    property p_ctrl_wr;
        done && avs_write_in && avs_address_in == 4'h0 && avs_byteenable_in[0] |-> ##2
            {frame_out, oh, lcd_drive_master_on_out} == {$past(avs_writedata_in[7], 2),
            4'h1 << $past(avs_writedata_in[6:5], 2), $past(avs_writedata_in[4], 2)};
    endproperty
    a_ctrl_wr: assert property (p_ctrl_wr) else $error("control write not applied");
    property p_master_off;
        !lcd_drive_master_on_out |-> pin_level_out == '0 && pin_drive_out == '0;
    endproperty
    a_master_off: assert property (p_master_off) else $error("pin not grounded");
    property p_rd_ctrl;
        done && avs_read_in && avs_address_in == 4'h0 |-> avs_readdata_out ==
            {24'h0, frame_out, oh[3] | oh[2], oh[3] | oh[1], lcd_drive_master_on_out, 4'h0};
    endproperty
    a_rd_ctrl: assert property (p_rd_ctrl) else $error("control readback wrong");
    property p_unmapped;
        done && avs_read_in && avs_address_in > 4'h3 |-> avs_readdata_out == '0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_seg_low;
        done && avs_write_in && avs_address_in == 4'h1 && avs_byteenable_in[0] |-> ##2
            pin_is_segment_out[7:0] == ($past(avs_writedata_in[7:0], 2) & 8'hCF);
    endproperty
    a_seg_low: assert property (p_seg_low) else $error("low roles wrong");
    property p_level;
        lcd_drive_master_on_out |-> pin_level_out[1:0] ==
            lv(frame_out, pin_is_segment_out[0], $past(port_data_in[0]));
    endproperty
    a_level: assert property (p_level) else $error("pin level wrong");
    property p_drive;
        {3'h0, pin_drive_out} == (`LDC_PIN_EXISTS &
            {3'h0, $past(pin_share_sel_in) & {`LDC_PIN_COUNT{lcd_drive_master_on_out}}});
    endproperty
    a_drive: assert property (p_drive) else $error("pin drive wrong");
    c_wr: cover property (done && avs_write_in);
    c_rd: cover property (done && avs_read_in && avs_address_in > 4'h3);
    c_on: cover property (lcd_drive_master_on_out && frame_out);
endmodule // ldc_top_properties

// File: ldc_top_tb.sv
// self-checking bench for the lcd drive register bank
// assumes ldc_top and its checker compiled before this file
`include "ldc_consts.vh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin num_errors++; $display("mismatch %0t %h", $time, a); end end

module ldc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam [15:0] LV_TBL = 16'hD22D;
    logic clk_in = 0;
    logic nrst_in = 0;
    logic [3:0] addr = 0;
    logic rd = 0;
    logic wr = 0;
    logic [31:0] wdat = 0;
    logic [3:0] be = 4'hF;
    logic [20:0] pdat = 0;
    logic [20:0] shr = 0;
    logic [31:0] q;
    logic [7:0] msk [4] = '{8'hF0, 8'hCF, 8'hDB, 8'h1F};
    wire [31:0] rdat;
    wire wt;
    wire [41:0] lvl;
    wire [20:0] drv;
    wire [20:0] seg;
    wire frm;
    wire mon;
    wire [3:0] bias;
    int num_errors = 0;
    int total_checks = 0;
    int cyc = 0;

    ldc_top uut (
        .clk_in(clk_in), .nrst_in(nrst_in), .avs_address_in(addr), .avs_read_in(rd),
        .avs_write_in(wr), .avs_writedata_in(wdat), .avs_byteenable_in(be),
        .avs_readdata_out(rdat), .avs_waitrequest_out(wt), .port_data_in(pdat),
        .pin_share_sel_in(shr), .pin_level_out(lvl), .pin_drive_out(drv),
        .pin_is_segment_out(seg), .frame_out(frm), .lcd_drive_master_on_out(mon),
        .bias_resistor_onehot_out(bias)
    );

    initial begin
        forever #20 clk_in = ~clk_in;
    end

    // ----
    // run control
    // ----
    task automatic test_done();
        if (num_errors == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 4000) begin
            num_errors++;
            test_done();
        end
    end

    function automatic [1:0] lv(input f, input s, input d);
        lv = LV_TBL[{f, s, d, 1'b0} +: 2];
    endfunction

    // ----
    // bus access
    // ----
    // waitrequest and readdata are taken at the rising edge, before the design updates
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [31:0] r);
        @(posedge clk_in);
        addr <= a;
        wr <= w;
        rd <= !w;
        wdat <= {24'h0, d};
        @(posedge clk_in);
        while (wt !== 1'b0) @(posedge clk_in);
        r = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        bus(1'b1, a, d, q);
    endtask

    task automatic rchk(input logic [3:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00, q);
        `CHK(q, {24'h0, e})
    endtask

    task automatic settle();
        @(posedge clk_in);
        @(negedge clk_in);
    endtask

    task automatic roles(input logic [7:0] l, m, h, input logic [20:0] e);
        wreg(4'h1, l);
        wreg(4'h2, m);
        wreg(4'h3, h);
        settle();
        `CHK(seg, e)
    endtask

    // ----
    // scenarios
    // ----
    initial begin
        repeat (10) @(posedge clk_in);
        nrst_in <= 1'b1;
        for (int i = 0; i < 4; i++) rchk(i[3:0], 8'h00);
        `CHK({bias, seg, drv, frm, mon}, {4'h1, 42'h0, 2'b00})
        for (int i = 0; i < 4; i++) begin
            wreg(i[3:0], 8'hFF);
            rchk(i[3:0], msk[i]);
        end
        wreg(4'h5, 8'hAA);
        rchk(4'h5, 8'h00);
        rchk(4'h1, 8'hCF);
        be <= 4'hE;
        wreg(4'h0, 8'h00);
        be <= 4'hF;
        rchk(4'h0, 8'hF0);
        roles(8'hFF, 8'hFF, 8'hFF, 21'h1FDBCF);
        roles(8'h45, 8'h12, 8'h09, 21'h091245);
        roles(8'h8A, 8'hC9, 8'h16, 21'h16C98A);
        for (int i = 0; i < 16; i++) begin
            wreg(4'h0, {i[3], i[2:1], 1'b1, 4'h0});
            pdat <= {21{i[0]}};
            shr <= 21'h1FFFFF;
            settle();
            `CHK(mon, 1'b1)
            `CHK(bias, 4'h1 << i[2:1])
            `CHK(frm, i[3])
            `CHK(lvl[3:0], {lv(i[3], 1'b1, i[0]), lv(i[3], 1'b0, i[0])})
            `CHK(drv, 21'h1FDBCF)
        end
        wreg(4'h0, 8'hE0);
        shr <= 21'h0AAAAA;
        settle();
        `CHK({lvl, drv, mon}, 64'h0)
        wreg(4'h0, 8'h10);
        settle();
        `CHK(drv, 21'h0A8A8A)
        @(posedge clk_in);
        nrst_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        nrst_in <= 1'b1;
        rchk(4'h0, 8'h00);
        rchk(4'h2, 8'h00);
        `CHK({drv, mon, frm, seg}, 44'h0)
        test_done();
    end
endmodule // ldc_top_tb

bind ldc_top ldc_top_properties chk (
    .clk_in(clk_in), .nrst_in(nrst_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .port_data_in(port_data_in), .pin_share_sel_in(pin_share_sel_in), .pin_level_out(pin_level_out),
    .pin_drive_out(pin_drive_out), .pin_is_segment_out(pin_is_segment_out), .frame_out(frame_out),
    .lcd_drive_master_on_out(lcd_drive_master_on_out), .bias_resistor_onehot_out(bias_resistor_onehot_out)
);
